// ===== rtl/ppfm_pkg.sv
package ppfm_pkg;

  localparam int P0_W = 4;
  localparam int P1_W = 2;
  localparam int P2_W = 3;
  localparam int P4_W = 4;
  localparam int P6_W = 2;
  localparam int P8_W = 6;

  // Port 2 bit positions of the serial functions.
  localparam int P2_SCK_BIT = 0;
  localparam int P2_TX_BIT  = 1;
  localparam int P2_RX_BIT  = 2;
  // Port 6 bit positions of the timer output and interrupt input.
  localparam int P6_TMR_BIT = 0;
  localparam int P6_INT_BIT = 1;

  // After reset every pin is an input in port mode.
  localparam logic [5:0] DIR_RST  = 6'h3F;
  localparam logic [5:0] LAT_RST  = 6'h00;
  localparam logic [5:0] MODE_RST = 6'h00;

  typedef enum logic [1:0] {
    PPFM_EDGE_NONE,
    PPFM_EDGE_RISE,
    PPFM_EDGE_FALL,
    PPFM_EDGE_BOTH
  } ppfm_edge_t;

  // Pin triple: level in, level out, output enable (low = driving).
  typedef struct packed {
    logic [5:0] in;
    logic [5:0] out;
    logic [5:0] oe_n;
  } ppfm_pad_t;

endpackage : ppfm_pkg

// ===== rtl/ppfm_port_bits.sv
`timescale 1ns/10ps
// One port slice: direction, output latch, pull-up and read-back.
module ppfm_port_bits #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  // Configuration
  input  wire logic [W-1:0] i_dir_in,
  input  wire logic [W-1:0] i_latch,
  input  wire logic [W-1:0] i_ctl_mode,
  input  wire logic [W-1:0] i_ctl_out,
  input  wire logic [W-1:0] i_ctl_drive,
  input  wire logic [W-1:0] i_pull_req,
  // Pins
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_pin,
  output logic      [W-1:0] o_pin_oe_n,
  output logic      [W-1:0] o_pull_en,
  // Read data
  output logic      [W-1:0] o_rdata
);
  logic [W-1:0] samp_q;
  logic [W-1:0] drv;

  always_comb begin
    for (int b = 0; b < W; b++) begin
      drv[b] = i_ctl_mode[b] ? i_ctl_drive[b] : !i_dir_in[b];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      samp_q  <= '0;
      o_rdata <= '0;
    end else begin
      samp_q  <= i_pin;
      for (int b = 0; b < W; b++) begin
        o_rdata[b] <= i_dir_in[b] ? samp_q[b] : i_latch[b];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_pin      <= '0;
      o_pin_oe_n <= '1;
      o_pull_en  <= '0;
    end else begin
      for (int b = 0; b < W; b++) begin
        o_pin[b] <= i_ctl_mode[b] ? i_ctl_out[b] : i_latch[b];
      end
      o_pin_oe_n <= ~drv;
      o_pull_en  <= i_pull_req & ~drv;
    end
  end
endmodule : ppfm_port_bits

// ===== rtl/ppfm_top.sv
`timescale 1ns/10ps
// Contract
// - Port 0 has four pins, each direction set by its own bit.
// - Port 1 has two pins, each direction set by its own bit.
// - Port 2 three pins are general I/O with per-bit direction.
// - Port 2 pull-ups are enabled per bit by its own option.
// - Port 2 control mode carries serial receive, transmit and clock per pin.
// - Port 4 four pins are general I/O with per-bit direction.
// - Port 4 pull-ups on when shared option or key-return mode asks.
// - Port 4 control mode feeds the four key-return inputs.
// - Port 6 two pins are general I/O with per-bit direction.
// - Port 6 control mode: timer output on one, interrupt input other.
// - Interrupt input edge is selectable: rising, falling or both.
// - Each port 8 pin selects port or LCD segment by function bit.
// - Port 8 port-mode direction follows its own direction bit.
// - Port 8 control mode outputs LCD segments 17 to 22.
// - Reset is active low.
module ppfm_top (
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  // Direction, 1 = input
  input  wire logic [3:0]            i_port0_direction_reg,
  input  wire logic [1:0]            i_port1_direction_reg,
  input  wire logic [2:0]            i_port2_direction_reg,
  input  wire logic [3:0]            i_port4_direction_reg,
  input  wire logic [1:0]            i_port6_direction_reg,
  input  wire logic [5:0]            i_port8_direction_reg,
  // Output latches
  input  wire logic [3:0]            i_port0_latch,
  input  wire logic [1:0]            i_port1_latch,
  input  wire logic [2:0]            i_port2_latch,
  input  wire logic [3:0]            i_port4_latch,
  input  wire logic [1:0]            i_port6_latch,
  input  wire logic [5:0]            i_port8_latch,
  // Pull-up and mode control
  input  wire logic [2:0]            i_shared_pullup_option_reg,
  input  wire logic [2:0]            i_port2_bitwise_pullup_reg,
  input  wire logic                  i_key_return_mode_reg,
  input  wire logic [2:0]            i_port2_ctl_mode,
  input  wire logic [3:0]            i_port4_ctl_mode,
  input  wire logic [1:0]            i_port6_ctl_mode,
  input  wire logic [5:0]            i_port8_function_select_reg,
  input  wire ppfm_pkg::ppfm_edge_t  i_int_edge_sel,
  // Peripheral side
  input  wire logic                  i_serial_tx_data,
  input  wire logic                  i_serial_clock_out,
  input  wire logic                  i_serial_clock_drive,
  input  wire logic                  i_timer_output_pin,
  input  wire logic [5:0]            i_lcd_segments_shared,
  output logic                       o_serial_rx_data,
  output logic                       o_serial_clock_in,
  output logic [3:0]                 o_key_return_inputs,
  output logic                       o_int_edge_pulse,
  // Pins
  input  wire logic [3:0]            i_port0_pins,
  input  wire logic [1:0]            i_port1_pins,
  input  wire logic [2:0]            i_port2_pins,
  input  wire logic [3:0]            i_port4_pins,
  input  wire logic [1:0]            i_port6_pins,
  input  wire logic [5:0]            i_port8_pins,
  output ppfm_pkg::ppfm_pad_t        o_p0_pad,
  output logic [1:0]                 o_port1_pins,
  output logic [1:0]                 o_port1_pins_oe_n,
  output logic [2:0]                 o_port2_pins,
  output logic [2:0]                 o_port2_pins_oe_n,
  output logic [3:0]                 o_port4_pins,
  output logic [3:0]                 o_port4_pins_oe_n,
  output logic [1:0]                 o_port6_pins,
  output logic [1:0]                 o_port6_pins_oe_n,
  output logic [5:0]                 o_port8_pins,
  output logic [5:0]                 o_port8_pins_oe_n,
  // Pull-up enables
  output logic [3:0]                 o_port0_pull_en,
  output logic [1:0]                 o_port1_pull_en,
  output logic [2:0]                 o_port2_pull_en,
  output logic [3:0]                 o_port4_pull_en,
  output logic [1:0]                 o_port6_pull_en,
  output logic [5:0]                 o_port8_pull_en,
  // Port read data
  output logic [3:0]                 o_port0_rdata,
  output logic [1:0]                 o_port1_rdata,
  output logic [2:0]                 o_port2_rdata,
  output logic [3:0]                 o_port4_rdata,
  output logic [1:0]                 o_port6_rdata,
  output logic [5:0]                 o_port8_rdata
);
  logic [2:0] p2_ctl_out;
  logic [2:0] p2_ctl_drv;
  logic [1:0] p6_ctl_out;
  logic [1:0] p6_ctl_drv;
  logic [3:0] p0_out;
  logic [3:0] p0_oe_n;
  logic       int_q;
  logic       int_prev_q;
  logic [1:0] int_armed_q;

  // Serial clock may be driven or received; transmit data is always driven
  // and receive data never, as the serial function dictates.
  always_comb begin
    p2_ctl_out = '0;
    p2_ctl_drv = '0;
    p2_ctl_out[ppfm_pkg::P2_SCK_BIT] = i_serial_clock_out;
    p2_ctl_drv[ppfm_pkg::P2_SCK_BIT] = i_serial_clock_drive;
    p2_ctl_out[ppfm_pkg::P2_TX_BIT]  = i_serial_tx_data;
    p2_ctl_drv[ppfm_pkg::P2_TX_BIT]  = 1'b1;
    p6_ctl_out = '0;
    p6_ctl_drv = '0;
    p6_ctl_out[ppfm_pkg::P6_TMR_BIT] = i_timer_output_pin;
    p6_ctl_drv[ppfm_pkg::P6_TMR_BIT] = 1'b1;
  end

  ppfm_port_bits #(.W(ppfm_pkg::P0_W)) u_p0 (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_dir_in    (i_port0_direction_reg),
    .i_latch     (i_port0_latch),
    .i_ctl_mode  (4'h0),
    .i_ctl_out   (4'h0),
    .i_ctl_drive (4'h0),
    .i_pull_req  ({4{i_shared_pullup_option_reg[0]}}),
    .i_pin       (i_port0_pins),
    .o_pin       (p0_out),
    .o_pin_oe_n  (p0_oe_n),
    .o_pull_en   (o_port0_pull_en),
    .o_rdata     (o_port0_rdata)
  );

  // The two spare lanes of the pin triple stay low and released.
  assign o_p0_pad = '{in:   {2'h0, i_port0_pins},
                      out:  {2'h0, p0_out},
                      oe_n: {2'h3, p0_oe_n}};

  ppfm_port_bits #(.W(ppfm_pkg::P1_W)) u_p1 (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_dir_in    (i_port1_direction_reg),
    .i_latch     (i_port1_latch),
    .i_ctl_mode  (2'h0),
    .i_ctl_out   (2'h0),
    .i_ctl_drive (2'h0),
    .i_pull_req  ({2{i_shared_pullup_option_reg[1]}}),
    .i_pin       (i_port1_pins),
    .o_pin       (o_port1_pins),
    .o_pin_oe_n  (o_port1_pins_oe_n),
    .o_pull_en   (o_port1_pull_en),
    .o_rdata     (o_port1_rdata)
  );

  ppfm_port_bits #(.W(ppfm_pkg::P2_W)) u_p2 (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_dir_in    (i_port2_direction_reg),
    .i_latch     (i_port2_latch),
    .i_ctl_mode  (i_port2_ctl_mode),
    .i_ctl_out   (p2_ctl_out),
    .i_ctl_drive (p2_ctl_drv),
    .i_pull_req  (i_port2_bitwise_pullup_reg),
    .i_pin       (i_port2_pins),
    .o_pin       (o_port2_pins),
    .o_pin_oe_n  (o_port2_pins_oe_n),
    .o_pull_en   (o_port2_pull_en),
    .o_rdata     (o_port2_rdata)
  );

  ppfm_port_bits #(.W(ppfm_pkg::P4_W)) u_p4 (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_dir_in    (i_port4_direction_reg | i_port4_ctl_mode),
    .i_latch     (i_port4_latch),
    .i_ctl_mode  (i_port4_ctl_mode),
    .i_ctl_out   (4'h0),
    .i_ctl_drive (4'h0),
    .i_pull_req  ({4{i_shared_pullup_option_reg[2]
                     | i_key_return_mode_reg}}),
    .i_pin       (i_port4_pins),
    .o_pin       (o_port4_pins),
    .o_pin_oe_n  (o_port4_pins_oe_n),
    .o_pull_en   (o_port4_pull_en),
    .o_rdata     (o_port4_rdata)
  );

  ppfm_port_bits #(.W(ppfm_pkg::P6_W)) u_p6 (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_dir_in    (i_port6_direction_reg),
    .i_latch     (i_port6_latch),
    .i_ctl_mode  (i_port6_ctl_mode),
    .i_ctl_out   (p6_ctl_out),
    .i_ctl_drive (p6_ctl_drv),
    .i_pull_req  (2'h0),
    .i_pin       (i_port6_pins),
    .o_pin       (o_port6_pins),
    .o_pin_oe_n  (o_port6_pins_oe_n),
    .o_pull_en   (o_port6_pull_en),
    .o_rdata     (o_port6_rdata)
  );

  ppfm_port_bits #(.W(ppfm_pkg::P8_W)) u_p8 (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_dir_in    (i_port8_direction_reg),
    .i_latch     (i_port8_latch),
    .i_ctl_mode  (i_port8_function_select_reg),
    .i_ctl_out   (i_lcd_segments_shared),
    .i_ctl_drive (6'h3F),
    .i_pull_req  (6'h00),
    .i_pin       (i_port8_pins),
    .o_pin       (o_port8_pins),
    .o_pin_oe_n  (o_port8_pins_oe_n),
    .o_pull_en   (o_port8_pull_en),
    .o_rdata     (o_port8_rdata)
  );

  // Inputs handed to the serial unit and key-return logic, registered.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_serial_rx_data    <= 1'b0;
      o_serial_clock_in   <= 1'b0;
      o_key_return_inputs <= 4'h0;
    end else begin
      o_serial_rx_data  <= i_port2_ctl_mode[ppfm_pkg::P2_RX_BIT]
                           & i_port2_pins[ppfm_pkg::P2_RX_BIT];
      o_serial_clock_in <= i_port2_ctl_mode[ppfm_pkg::P2_SCK_BIT]
                           & i_port2_pins[ppfm_pkg::P2_SCK_BIT];
      o_key_return_inputs <= i_port4_ctl_mode & i_port4_pins;
    end
  end

  // Edge detector on the interrupt pin. Two cycles of arming let both history
  // stages hold real pin levels, so neither leaving reset nor entering
  // control mode reports a false edge.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      int_q            <= 1'b0;
      int_prev_q       <= 1'b0;
      int_armed_q      <= 2'h0;
      o_int_edge_pulse <= 1'b0;
    end else begin
      int_q       <= i_port6_pins[ppfm_pkg::P6_INT_BIT];
      int_prev_q  <= int_q;
      int_armed_q <= {int_armed_q[0], i_port6_ctl_mode[ppfm_pkg::P6_INT_BIT]};
      o_int_edge_pulse <= 1'b0;
      if (&int_armed_q && i_port6_ctl_mode[ppfm_pkg::P6_INT_BIT]) begin
        unique case (i_int_edge_sel)
          ppfm_pkg::PPFM_EDGE_NONE: o_int_edge_pulse <= 1'b0;
          ppfm_pkg::PPFM_EDGE_RISE:
            o_int_edge_pulse <= int_q & ~int_prev_q;
          ppfm_pkg::PPFM_EDGE_FALL:
            o_int_edge_pulse <= ~int_q & int_prev_q;
          ppfm_pkg::PPFM_EDGE_BOTH:
            o_int_edge_pulse <= int_q ^ int_prev_q;
        endcase
      end
    end
  end
endmodule : ppfm_top

// ===== tb/ppfm_checker.sv
`timescale 1ns/10ps
module ppfm_checker (
  // Clock, reset and controls
  input wire logic                 i_ref_clk, i_rst_n,
  input wire logic                 i_key_return_mode_reg, i_serial_tx_data,
  input wire logic                 i_timer_output_pin, o_int_edge_pulse,
  input wire ppfm_pkg::ppfm_edge_t i_int_edge_sel,
  input wire logic [3:0]           i_port0_direction_reg, i_port0_pins,
  input wire logic [3:0]           i_port4_direction_reg, i_port4_ctl_mode,
  input wire logic [2:0]           i_shared_pullup_option_reg,
  input wire logic [2:0]           i_port2_ctl_mode,
  input wire logic [1:0]           i_port6_ctl_mode,
  input wire logic [5:0]           i_port8_function_select_reg,
  input wire logic [5:0]           i_lcd_segments_shared, i_port8_direction_reg,
  // Design outputs
  input wire ppfm_pkg::ppfm_pad_t  o_p0_pad,
  input wire logic [3:0]           o_port0_pull_en, o_port0_rdata,
  input wire logic [3:0]           o_port4_pull_en,
  input wire logic [2:0]           o_port2_pins, o_port2_pins_oe_n,
  input wire logic [1:0]           o_port6_pins, o_port6_pins_oe_n,
  input wire logic [5:0]           o_port8_pins, o_port8_pins_oe_n
);
  // Reset history, so that no check looks back into a reset cycle.
  logic [1:0] run_q;
  always_ff @(posedge i_ref_clk) run_q <= {run_q[0], i_rst_n};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_p0_dir;
    run_q[0] |-> o_p0_pad.oe_n[3:0] == $past(i_port0_direction_reg);
  endproperty
  a_p0_dir: assert property (p_p0_dir) else $error("port0 enable");
  property p_p0_pull;
    run_q[0] |-> o_port0_pull_en == ($past(i_port0_direction_reg)
      & {4{$past(i_shared_pullup_option_reg[0])}});
  endproperty
  a_p0_pull: assert property (p_p0_pull) else $error("port0 pull");
  property p_p0_read;
    &run_q && $past(i_port0_direction_reg, 2) == 4'hF
      && $past(i_port0_direction_reg) == 4'hF
      |-> o_port0_rdata == $past(i_port0_pins, 2);
  endproperty
  a_p0_read: assert property (p_p0_read) else $error("port0 read");
  property p_p2_tx;
    run_q[0] && $past(i_port2_ctl_mode[1])
      |-> !o_port2_pins_oe_n[1] && o_port2_pins[1] == $past(i_serial_tx_data);
  endproperty
  a_p2_tx: assert property (p_p2_tx) else $error("serial tx");
  property p_p4_pull;
    run_q[0] && $past(i_port4_ctl_mode) == 4'h0 |-> o_port4_pull_en ==
      ($past(i_port4_direction_reg) & {4{$past(i_key_return_mode_reg
      | i_shared_pullup_option_reg[2])}});
  endproperty
  a_p4_pull: assert property (p_p4_pull) else $error("port4 pull");
  property p_tmr;
    run_q[0] && $past(i_port6_ctl_mode[0])
      |-> !o_port6_pins_oe_n[0]
      && o_port6_pins[0] == $past(i_timer_output_pin);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer out");
  property p_int_none;
    (i_int_edge_sel == ppfm_pkg::PPFM_EDGE_NONE)[*6] |=> !o_int_edge_pulse;
  endproperty
  a_int_none: assert property (p_int_none) else $error("int pulse");
  property p_p8;
    run_q[0] |-> o_port8_pins_oe_n == ($past(i_port8_direction_reg)
      & ~$past(i_port8_function_select_reg)) && (o_port8_pins
      & $past(i_port8_function_select_reg)) == ($past(i_lcd_segments_shared)
      & $past(i_port8_function_select_reg));
  endproperty
  a_p8: assert property (p_p8) else $error("port8 mux");
  property p_rst;
    disable iff (1'b0) !i_rst_n |=> o_port8_pins_oe_n == 6'h3F
      && o_port0_pull_en == 4'h0 && !o_int_edge_pulse;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule : ppfm_checker

bind ppfm_top ppfm_checker u_ppfm_checker (.*);

// ===== tb/ppfm_board.sv
`timescale 1ns/10ps
// Board pins: the device wins when driving, then an external driver, then a
// pull-up; a floating pin shows a pattern that flips every cycle.
module ppfm_board #(
  parameter int W = 21
) (
  input  wire logic         i_ref_clk,
  input  wire logic [W-1:0] i_out, i_oe_n, i_pull_en, i_drv, i_val,
  output logic      [W-1:0] o_level
);
  logic [W-1:0] wander_q = '0;
  always @(posedge i_ref_clk) wander_q <= ~wander_q;
  always_comb begin
    for (int k = 0; k < W; k++) begin
      if (!i_oe_n[k]) o_level[k] = i_out[k];
      else if (i_drv[k]) o_level[k] = i_val[k];
      else o_level[k] = i_pull_en[k] | wander_q[k];
    end
  end
endmodule : ppfm_board

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic i_ref_clk, i_rst_n, i_key_return_mode_reg, i_serial_tx_data;
  logic i_serial_clock_out, i_serial_clock_drive, i_timer_output_pin;
  logic o_serial_rx_data, o_serial_clock_in, o_int_edge_pulse;
  logic [3:0] i_port0_direction_reg, i_port0_latch, i_port0_pins;
  logic [3:0] i_port4_direction_reg, i_port4_latch, i_port4_pins;
  logic [3:0] i_port4_ctl_mode, o_key_return_inputs, o_port4_pins;
  logic [3:0] o_port4_pins_oe_n, o_port0_pull_en, o_port4_pull_en;
  logic [3:0] o_port0_rdata, o_port4_rdata;
  logic [1:0] i_port1_direction_reg, i_port1_latch, i_port1_pins;
  logic [1:0] i_port6_direction_reg, i_port6_latch, i_port6_pins;
  logic [1:0] i_port6_ctl_mode, o_port1_pins, o_port1_pins_oe_n;
  logic [1:0] o_port6_pins, o_port6_pins_oe_n, o_port1_pull_en;
  logic [1:0] o_port6_pull_en, o_port1_rdata, o_port6_rdata;
  logic [2:0] i_port2_direction_reg, i_port2_latch, i_port2_pins;
  logic [2:0] i_shared_pullup_option_reg, i_port2_bitwise_pullup_reg;
  logic [2:0] i_port2_ctl_mode, o_port2_pins, o_port2_pins_oe_n;
  logic [2:0] o_port2_pull_en, o_port2_rdata;
  logic [5:0] i_port8_direction_reg, i_port8_latch, i_port8_pins;
  logic [5:0] i_port8_function_select_reg, i_lcd_segments_shared;
  logic [5:0] o_port8_pins, o_port8_pins_oe_n, o_port8_pull_en;
  logic [5:0] o_port8_rdata;
  logic [20:0] ext_drv, ext_val, s;
  ppfm_pkg::ppfm_edge_t i_int_edge_sel;
  ppfm_pkg::ppfm_pad_t  o_p0_pad;
  int miscompares, samples_checked, nr, nf;
  typedef struct packed {logic [5:0] dir, lat, val; logic [2:0] pu; logic k;}
    ppfm_tb_row_t;
  ppfm_tb_row_t rows[5] = '{'{6'h3F, 6'h00, 6'h15, 3'h7, 1'b0},
    '{6'h00, 6'h2A, 6'h00, 3'h7, 1'b1}, '{6'h2A, 6'h15, 6'h3F, 3'h0, 1'b0},
    '{6'h3F, 6'h3F, 6'h0A, 3'h3, 1'b1}, '{6'h15, 6'h3F, 6'h00, 3'h5, 1'b0}};
  // Every port side by side: p8, p6, p4, p2, p1, p0.
  wire [20:0] oe = {o_port8_pins_oe_n, o_port6_pins_oe_n, o_port4_pins_oe_n,
    o_port2_pins_oe_n, o_port1_pins_oe_n, o_p0_pad.oe_n[3:0]};
  wire [20:0] rd = {o_port8_rdata, o_port6_rdata, o_port4_rdata,
    o_port2_rdata, o_port1_rdata, o_port0_rdata};
  wire [20:0] pl = {o_port8_pull_en, o_port6_pull_en, o_port4_pull_en,
    o_port2_pull_en, o_port1_pull_en, o_port0_pull_en};
  wire [20:0] po = {o_port8_pins, o_port6_pins, o_port4_pins, o_port2_pins,
    o_port1_pins, o_p0_pad.out[3:0]};
  ppfm_top u_ppfm_top (.*);
  ppfm_board u_ppfm_board (.i_ref_clk, .i_oe_n(oe), .i_pull_en(pl),
    .i_out(po), .i_drv(ext_drv), .i_val(ext_val),
    .o_level({i_port8_pins, i_port6_pins, i_port4_pins, i_port2_pins,
    i_port1_pins, i_port0_pins}));
  function automatic logic [20:0] spread(input logic [5:0] v);
    return {v, v[1:0], v[3:0], v[2:0], v[1:0], v[3:0]};
  endfunction : spread
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic apply(input ppfm_tb_row_t r);
    {i_port8_direction_reg, i_port6_direction_reg, i_port4_direction_reg,
      i_port2_direction_reg, i_port1_direction_reg,
      i_port0_direction_reg} <= spread(r.dir);
    {i_port8_latch, i_port6_latch, i_port4_latch, i_port2_latch,
      i_port1_latch, i_port0_latch} <= spread(r.lat);
    i_shared_pullup_option_reg <= r.pu;
    i_port2_bitwise_pullup_reg <= r.pu;
    i_key_return_mode_reg <= r.k;
    ext_drv <= spread(r.dir);
    ext_val <= spread(r.val);
  endtask : apply
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    #100us;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    i_rst_n = 1'b0;
    {i_port2_ctl_mode, i_port4_ctl_mode, i_port6_ctl_mode} = '0;
    i_lcd_segments_shared = 6'h3C;
    i_int_edge_sel = ppfm_pkg::PPFM_EDGE_NONE;
    {i_serial_tx_data, i_serial_clock_out} = 2'b10;
    {i_serial_clock_drive, i_timer_output_pin} = 2'b01;
    i_port8_function_select_reg = 6'h00;
    apply(rows[0]);
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    foreach (rows[i]) begin
      @(posedge i_ref_clk);
      apply(rows[i]);
      repeat (3) @(posedge i_ref_clk);
      #1;
      s = spread(rows[i].dir);
      chk(oe, s);
      chk(rd, (s & spread(rows[i].val)) | (~s & spread(rows[i].lat)));
      chk(pl, {8'h00, s[12:9] & {4{rows[i].pu[2] | rows[i].k}},
        s[8:6] & rows[i].pu, s[5:4] & {2{rows[i].pu[1]}},
        s[3:0] & {4{rows[i].pu[0]}}});
      chk(po, spread(rows[i].lat));
      chk({3'h0, o_p0_pad}, {5'h00, i_port0_pins, 2'h0,
        rows[i].lat[3:0], 2'h3, rows[i].dir[3:0]});
    end
    @(posedge i_ref_clk);
    apply('{6'h3F, 6'h00, 6'h0D, 3'h0, 1'b0});
    {i_port2_ctl_mode, i_port4_ctl_mode, i_port6_ctl_mode} <= '1;
    i_port8_function_select_reg <= 6'h2A;
    repeat (4) @(posedge i_ref_clk);
    #1;
    chk(oe, {6'h15, 2'b10, 4'hF, 3'b101, 2'h3, 4'hF});
    chk({7'h00, o_key_return_inputs, o_serial_rx_data,
      o_serial_clock_in, o_port2_pins[1], o_port6_pins[0],
      o_port8_pins & 6'h2A}, {7'h00, 4'hD, 4'hF, 6'h28});
    for (int e = 0; e < 4; e++) begin
      @(posedge i_ref_clk);
      i_int_edge_sel <= ppfm_pkg::ppfm_edge_t'(e[1:0]);
      {nr, nf} = '0;
      repeat (6) @(posedge i_ref_clk);
      ext_val[14] <= 1'b1;
      repeat (6) @(posedge i_ref_clk) if (o_int_edge_pulse === 1'b1) nr++;
      ext_val[14] <= 1'b0;
      repeat (6) @(posedge i_ref_clk) if (o_int_edge_pulse === 1'b1) nf++;
      chk(21'(nr * 8 + nf), 21'(e[0] * 8 + e[1]));
    end
    // Serial clock driven out: the device owns the pin against the board.
    i_serial_clock_drive <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk({16'h0000, o_port2_pins_oe_n, o_port2_pins[0],
      o_serial_clock_in}, {16'h0000, 3'b100, 2'b00});
    @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    ext_val[14] <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk(oe, '1);
    chk(pl | rd, '0);
    // Leave reset with the interrupt pin idle high: no edge may be reported.
    @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    nr = 0;
    repeat (6) @(posedge i_ref_clk) if (o_int_edge_pulse === 1'b1) nr++;
    chk(21'(nr), 21'h0);
    #1;
    chk(oe, {6'h15, 2'b10, 4'hF, 3'b100, 2'h3, 4'hF});
    tally_and_finish();
  end
endmodule : tb
